// [cesir_pkg.sv]
// constants for the comparator event, shortcut and interrupt registers
package cesir_pkg;
	localparam int          CESIR_AW           = 12;
	localparam int          CESIR_NEV          = 4;
	localparam int          CESIR_NLINK        = 5;
	// register byte offsets
	localparam logic [11:0] CESIR_OFF_READY    = 12'h100;
	localparam logic [11:0] CESIR_OFF_DOWN     = 12'h104;
	localparam logic [11:0] CESIR_OFF_UP       = 12'h108;
	localparam logic [11:0] CESIR_OFF_ANY_CROSSING_EVENT    = 12'h10C;
	localparam logic [11:0] CESIR_OFF_LINKS    = 12'h200;
	localparam logic [11:0] CESIR_OFF_IEN      = 12'h300;
	localparam logic [11:0] CESIR_OFF_IEN_SET  = 12'h304;
	localparam logic [11:0] CESIR_OFF_IEN_CLR  = 12'h308;
	localparam logic [11:0] CESIR_OFF_STATUS   = 12'h310;
	// event bit positions, shared by flags, enables and status
	localparam int          CESIR_EV_READY     = 0;
	localparam int          CESIR_EV_DOWN      = 1;
	localparam int          CESIR_EV_UP        = 2;
	localparam int          CESIR_EV_ANY_CROSSING_EVENT     = 3;
	// link bit positions
	localparam int          CESIR_LK_RDY_SMP   = 0;
	localparam int          CESIR_LK_RDY_HALT  = 1;
	localparam int          CESIR_LK_DOWN_HALT = 2;
	localparam int          CESIR_LK_UP_HALT   = 3;
	localparam int          CESIR_LK_ANY_HALT  = 4;
	// reset values
	localparam logic [3:0]  CESIR_RST_FLAGS    = 4'h0;
	localparam logic [4:0]  CESIR_RST_LINKS    = 5'h00;
	localparam logic [3:0]  CESIR_RST_IEN      = 4'h0;
	localparam logic [31:0] CESIR_RST_RDATA    = 32'h00000000;
	localparam logic [1:0]  CESIR_HRESP_OKAY   = 2'h0;
endpackage : cesir_pkg

// [cesir_regs.sv]
// comparator event flags, event-to-task links and interrupt enables
//
// Summary of operation
// - crossing flag at 0x10C, set on crossings
// - link register 0x200, five enable bits
// - ready event triggers sample when linked
// - ready event triggers stop when linked
// - downward crossing triggers stop when linked
// - upward crossing triggers stop when linked
// - any crossing triggers stop when linked
// - interrupt enable register 0x300, four bits
// - writing one at 0x304 sets enables
// - reading 0x304 returns the enable state
// - writing one at 0x308 clears enables
// - ready event raised when comparator output valid
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module cesir_regs (
	input  wire logic                      i_mclk,
	input  wire logic                      i_reset_n,
	input  wire logic                      i_hsel,
	input  wire logic [cesir_pkg::CESIR_AW-1:0] i_haddr,
	input  wire logic [1:0]                i_htrans,
	input  wire logic                      i_hwrite,
	input  wire logic [2:0]                i_hsize,
	input  wire logic [31:0]               i_hwdata,
	input  wire logic                      i_hready,
	output logic                           o_hreadyout,
	output logic [31:0]                    o_hrdata,
	output logic [1:0]                     o_hresp,
	input  wire logic                      i_cmp_ready,
	input  wire logic                      i_cmp_down,
	input  wire logic                      i_cmp_up,
	input  wire logic                      i_cmp_any_crossing_event,
	output logic                           o_task_sample,
	output logic                           o_task_stop,
	output logic                           o_irq
);
	import cesir_pkg::*;

	// comparator indications come from the analog side
	logic [CESIR_NEV-1:0] raw;
	logic [CESIR_NEV-1:0] sync1_reg;
	logic [CESIR_NEV-1:0] sync2_reg;
	logic [CESIR_NEV-1:0] prev_reg;
	logic [CESIR_NEV-1:0] edge_ev;
	logic [CESIR_NEV-1:0] ev;

	assign raw = {i_cmp_any_crossing_event, i_cmp_up, i_cmp_down, i_cmp_ready};

	genvar gi;
	generate
		for (gi = 0; gi < CESIR_NEV; gi++) begin : g_sync
			always_ff @(posedge i_mclk) begin
				if (!i_reset_n) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
					prev_reg[gi]  <= 1'b0;
				end else begin
					sync1_reg[gi] <= raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					prev_reg[gi]  <= sync2_reg[gi];
				end
			end
			assign edge_ev[gi] = sync2_reg[gi] & ~prev_reg[gi];
		end
	endgenerate

	// a crossing either way also counts as a crossing event
	always_comb begin
		ev                 = edge_ev;
		ev[CESIR_EV_ANY_CROSSING_EVENT] = edge_ev[CESIR_EV_ANY_CROSSING_EVENT]
			| edge_ev[CESIR_EV_DOWN] | edge_ev[CESIR_EV_UP];
	end

	// bus slave
	logic                 rd_req;
	logic                 wr_req;
	logic                 stall;
	logic                 wr_pend_reg;
	logic                 wr_pend_next;
	logic [CESIR_AW-1:0]  wr_addr_reg;
	logic [CESIR_AW-1:0]  wr_addr_next;
	logic [31:0]          rdata_reg;
	logic [31:0]          rdata_next;
	logic                 commit;

	// a read right behind a write waits one cycle so it sees the new value
	assign stall  = wr_pend_reg & i_hsel & i_htrans[1] & ~i_hwrite;
	assign rd_req = i_hsel & i_htrans[1] & i_hready & ~i_hwrite & ~stall;
	assign wr_req = i_hsel & i_htrans[1] & i_hready & i_hwrite;
	assign commit = wr_pend_reg;

	assign o_hreadyout = ~stall;
	assign o_hresp     = CESIR_HRESP_OKAY;
	assign o_hrdata    = rdata_reg;

	// register state
	logic [CESIR_NEV-1:0]   flag_reg;
	logic [CESIR_NEV-1:0]   flag_next;
	logic [CESIR_NLINK-1:0] link_reg;
	logic [CESIR_NLINK-1:0] link_next;
	logic [CESIR_NEV-1:0]   ien_reg;
	logic [CESIR_NEV-1:0]   ien_next;
	logic                   smp_reg;
	logic                   smp_next;
	logic                   halt_reg;
	logic                   halt_next;
	logic                   irq_reg;
	logic                   irq_next;
	logic [CESIR_NEV-1:0]   clr;
	logic [CESIR_NEV-1:0]   wd;

	assign wd = i_hwdata[CESIR_NEV-1:0];

	always_comb begin
		wr_pend_next = wr_req;
		wr_addr_next = wr_req ? i_haddr : wr_addr_reg;
		rdata_next   = rdata_reg;
		if (rd_req) begin
			rdata_next = CESIR_RST_RDATA;
			case ({i_haddr[CESIR_AW-1:2], 2'b00})
				CESIR_OFF_READY: rdata_next[0] = flag_reg[CESIR_EV_READY];
				CESIR_OFF_DOWN:  rdata_next[0] = flag_reg[CESIR_EV_DOWN];
				CESIR_OFF_UP:    rdata_next[0] = flag_reg[CESIR_EV_UP];
				CESIR_OFF_ANY_CROSSING_EVENT: rdata_next[0] = flag_reg[CESIR_EV_ANY_CROSSING_EVENT];
				CESIR_OFF_LINKS: rdata_next[CESIR_NLINK-1:0] = link_reg;
				CESIR_OFF_IEN:     rdata_next[CESIR_NEV-1:0] = ien_reg;
				CESIR_OFF_IEN_SET: rdata_next[CESIR_NEV-1:0] = ien_reg;
				CESIR_OFF_IEN_CLR: rdata_next[CESIR_NEV-1:0] = ien_reg;
				CESIR_OFF_STATUS:  rdata_next[CESIR_NEV-1:0] = flag_reg;
				default: rdata_next = CESIR_RST_RDATA;
			endcase
		end
	end

	always_comb begin
		clr       = '0;
		link_next = link_reg;
		ien_next  = ien_reg;
		if (commit) begin
			case ({wr_addr_reg[CESIR_AW-1:2], 2'b00})
				CESIR_OFF_READY: clr[CESIR_EV_READY] = ~i_hwdata[0];
				CESIR_OFF_DOWN:  clr[CESIR_EV_DOWN]  = ~i_hwdata[0];
				CESIR_OFF_UP:    clr[CESIR_EV_UP]    = ~i_hwdata[0];
				CESIR_OFF_ANY_CROSSING_EVENT: clr[CESIR_EV_ANY_CROSSING_EVENT] = ~i_hwdata[0];
				CESIR_OFF_LINKS: link_next = i_hwdata[CESIR_NLINK-1:0];
				CESIR_OFF_IEN:     ien_next = wd;
				CESIR_OFF_IEN_SET: ien_next = ien_reg | wd;
				CESIR_OFF_IEN_CLR: ien_next = ien_reg & ~wd;
				CESIR_OFF_STATUS:  clr = wd;
				default: clr = '0;
			endcase
		end
		// a new event in the clearing cycle is kept
		flag_next = ev | (flag_reg & ~clr);
		smp_next  = link_reg[CESIR_LK_RDY_SMP] & ev[CESIR_EV_READY];
		halt_next = (link_reg[CESIR_LK_RDY_HALT] & ev[CESIR_EV_READY])
			| (link_reg[CESIR_LK_DOWN_HALT] & ev[CESIR_EV_DOWN])
			| (link_reg[CESIR_LK_UP_HALT] & ev[CESIR_EV_UP])
			| (link_reg[CESIR_LK_ANY_HALT] & ev[CESIR_EV_ANY_CROSSING_EVENT]);
		irq_next  = |(flag_next & ien_next);
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
			rdata_reg   <= CESIR_RST_RDATA;
			flag_reg    <= CESIR_RST_FLAGS;
			link_reg    <= CESIR_RST_LINKS;
			ien_reg     <= CESIR_RST_IEN;
			smp_reg     <= 1'b0;
			halt_reg    <= 1'b0;
			irq_reg     <= 1'b0;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			rdata_reg   <= rdata_next;
			flag_reg    <= flag_next;
			link_reg    <= link_next;
			ien_reg     <= ien_next;
			smp_reg     <= smp_next;
			halt_reg    <= halt_next;
			irq_reg     <= irq_next;
		end
	end

	assign o_task_sample = smp_reg;
	assign o_task_stop   = halt_reg;
	assign o_irq         = irq_reg;

	// checks
	sequence s_wr(logic [11:0] a);
		commit && ({wr_addr_reg[CESIR_AW-1:2], 2'b00} == a);
	endsequence

	a_any_crossing_event_flag_set: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		(edge_ev[CESIR_EV_DOWN] || edge_ev[CESIR_EV_UP])
		|=> flag_reg[CESIR_EV_ANY_CROSSING_EVENT])
		else $error("crossing did not set the crossing flag");

	a_link_write: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		s_wr(CESIR_OFF_LINKS) |=> link_reg == $past(i_hwdata[4:0]))
		else $error("link register not written");

	a_sample_link: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		(link_reg[CESIR_LK_RDY_SMP] && ev[CESIR_EV_READY])
		|=> o_task_sample ##1 !o_task_sample)
		else $error("sample pulse missing or too long");

	a_no_sample: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		!link_reg[CESIR_LK_RDY_SMP] |=> !o_task_sample)
		else $error("sample without enabled link");

	a_stop_ready: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		(link_reg[CESIR_LK_RDY_HALT] && ev[CESIR_EV_READY]) |=> o_task_stop)
		else $error("ready did not stop");

	a_stop_down: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		(link_reg[CESIR_LK_DOWN_HALT] && ev[CESIR_EV_DOWN]) |=> o_task_stop)
		else $error("downward crossing did not stop");

	a_stop_up: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		(link_reg[CESIR_LK_UP_HALT] && ev[CESIR_EV_UP]) |=> o_task_stop)
		else $error("upward crossing did not stop");

	a_stop_any: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		(link_reg[CESIR_LK_ANY_HALT] && ev[CESIR_EV_ANY_CROSSING_EVENT]) |=> o_task_stop)
		else $error("crossing did not stop");

	a_enable_write: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		s_wr(CESIR_OFF_IEN) |=> ien_reg == $past(i_hwdata[3:0]))
		else $error("enable register not written");

	a_set_alias: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		s_wr(CESIR_OFF_IEN_SET)
		|=> ien_reg == ($past(ien_reg) | $past(i_hwdata[3:0])))
		else $error("set alias wrong");

	a_set_readback: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		(rd_req && i_haddr == CESIR_OFF_IEN_SET)
		|=> o_hrdata == {28'h0000000, $past(ien_reg)})
		else $error("set alias read wrong");

	a_clear_alias: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		s_wr(CESIR_OFF_IEN_CLR)
		|=> ien_reg == ($past(ien_reg) & ~$past(i_hwdata[3:0])))
		else $error("clear alias wrong");

	a_ready_flag: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		$rose(sync2_reg[CESIR_EV_READY]) |=> flag_reg[CESIR_EV_READY])
		else $error("ready event lost");

	a_zero_keeps: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		(s_wr(CESIR_OFF_IEN_SET) or s_wr(CESIR_OFF_IEN_CLR))
		|=> ((ien_reg ^ $past(ien_reg)) & ~$past(i_hwdata[3:0])) == 4'h0)
		else $error("alias changed an unwritten bit");

	a_irq_level: assert property (
		@(posedge i_mclk) disable iff (!i_reset_n)
		##1 (o_irq == |(flag_reg & ien_reg)))
		else $error("interrupt level wrong");

endmodule : cesir_regs

// [cesir_regs_tb.sv]
// self-checking bench for the comparator event, link and interrupt registers
`timescale 1ns/1ps
module testbench;
	import cesir_pkg::*;
	logic        mclk;
	logic        reset_n;
	logic        hsel;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic [1:0]  hresp;
	logic [3:0]  cmp;
	logic        task_sample;
	logic        task_stop;
	logic        irq;
	logic [31:0] rd;
	int          error_cnt;
	int          comparisons;
	int          cyc;
	int          n_smp;
	int          n_stop;
	cesir_regs i_cesir_regs (.i_mclk(mclk), .i_reset_n(reset_n), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout),
		.o_hrdata(hrdata), .o_hresp(hresp), .i_cmp_ready(cmp[0]),
		.i_cmp_down(cmp[1]), .i_cmp_up(cmp[2]), .i_cmp_any_crossing_event(cmp[3]),
		.o_task_sample(task_sample), .o_task_stop(task_stop), .o_irq(irq));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic print_verdict;
		if (error_cnt == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// entered right after a rising edge; holds each phase until hready
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		r = hrdata;
		// hsel stays up: idle htrans keeps the bus quiet, and a call that
		// follows at once never drives hsel twice in one time step
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d, rd);
	endtask : wr
	task automatic rchk(input string what, input logic [11:0] a,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0, rd);
		chk(what, rd, exp);
	endtask : rchk
	// raises one comparator input for a few cycles and counts task pulses
	task automatic fire(input int ev);
		n_smp = 0;
		n_stop = 0;
		for (int k = 0; k < 12; k++) begin
			@(posedge mclk);
			cmp[ev] <= (k < 5);
			#1;
			if (task_sample === 1'b1) n_smp++;
			if (task_stop === 1'b1) n_stop++;
		end
	endtask : fire
	task automatic test_reset_map;
		rchk("any_crossing_event flag rst", CESIR_OFF_ANY_CROSSING_EVENT, 32'h0);
		rchk("links rst", CESIR_OFF_LINKS, 32'h0);
		rchk("enable rst", CESIR_OFF_IEN, 32'h0);
		rchk("set alias rst", CESIR_OFF_IEN_SET, 32'h0);
		wr(CESIR_OFF_LINKS, 32'hFFFFFFFF);
		rchk("links all", CESIR_OFF_LINKS, 32'h0000001F);
		wr(CESIR_OFF_LINKS, 32'h0);
		wr(12'h0FC, 32'hFFFFFFFF);
		rchk("unmapped", 12'h0FC, 32'h0);
		chk("okay response", hresp, 32'h0);
	endtask : test_reset_map
	task automatic test_links;
		int          ev[5] = '{0, 0, 1, 2, 3};
		logic [31:0] smp[5] = '{1, 0, 0, 0, 0};
		fire(CESIR_EV_DOWN);
		chk("unlinked stop", n_stop, 0);
		for (int k = 0; k < CESIR_NLINK; k++) begin
			@(posedge mclk);
			wr(CESIR_OFF_LINKS, 32'h1 << k);
			fire(ev[k]);
			chk("link sample", n_smp, smp[k]);
			chk("link stop", n_stop, 1 - smp[k]);
		end
		fire(CESIR_EV_UP);
		chk("any link by up", n_stop, 32'h1);
		@(posedge mclk);
		wr(CESIR_OFF_LINKS, 32'h0);
	endtask : test_links
	task automatic test_enables;
		wr(CESIR_OFF_IEN, 32'hFFFFFFF5);
		rchk("enable rw", CESIR_OFF_IEN, 32'h5);
		rchk("set alias rd", CESIR_OFF_IEN_SET, 32'h5);
		rchk("clr alias rd", CESIR_OFF_IEN_CLR, 32'h5);
		wr(CESIR_OFF_IEN_SET, 32'hA);
		rchk("set alias wr", CESIR_OFF_IEN, 32'hF);
		wr(CESIR_OFF_IEN_SET, 32'h0);
		rchk("set zeros", CESIR_OFF_IEN, 32'hF);
		wr(CESIR_OFF_IEN_CLR, 32'h3);
		rchk("clr alias wr", CESIR_OFF_IEN_SET, 32'hC);
		wr(CESIR_OFF_IEN_CLR, 32'h0);
		rchk("clr zeros", CESIR_OFF_IEN, 32'hC);
		wr(CESIR_OFF_IEN, 32'h0);
	endtask : test_enables
	task automatic test_irq;
		wr(CESIR_OFF_STATUS, 32'hF);
		rchk("flags cleared", CESIR_OFF_ANY_CROSSING_EVENT, 32'h0);
		wr(CESIR_OFF_IEN, 32'h8);
		fire(CESIR_EV_UP);
		chk("irq any_crossing_event", irq, 1'b1);
		rchk("any_crossing_event by up", CESIR_OFF_ANY_CROSSING_EVENT, 32'h1);
		wr(CESIR_OFF_ANY_CROSSING_EVENT, 32'h0);
		repeat (2) @(posedge mclk);
		chk("irq after clear", irq, 1'b0);
		rchk("any_crossing_event cleared", CESIR_OFF_ANY_CROSSING_EVENT, 32'h0);
		wr(CESIR_OFF_IEN, 32'h0);
		fire(CESIR_EV_DOWN);
		chk("irq masked", irq, 1'b0);
		rchk("any_crossing_event by down", CESIR_OFF_ANY_CROSSING_EVENT, 32'h1);
		wr(CESIR_OFF_IEN_SET, 32'h8);
		repeat (2) @(posedge mclk);
		chk("irq on set", irq, 1'b1);
		wr(CESIR_OFF_IEN_CLR, 32'h8);
		repeat (2) @(posedge mclk);
		chk("irq on clear", irq, 1'b0);
		wr(CESIR_OFF_IEN, 32'h1);
		fire(CESIR_EV_READY);
		chk("irq ready", irq, 1'b1);
	endtask : test_irq
	initial begin
		error_cnt = 0;
		comparisons = 0;
		cyc = 0;
		reset_n = 1'b0;
		hsel = 1'b0;
		haddr = 12'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		cmp = 4'h0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		test_reset_map();
		test_links();
		test_enables();
		test_irq();
		print_verdict();
	end
endmodule : testbench
